// ==== common/tdr_cfg.svh ====
// Constants of the touch decision and reporting block.
// Summary of operation
// - Touch needs ticks above threshold plus threshold times shared hysteresis percent.
// - Release needs ticks below threshold minus threshold times hysteresis percent.
// - Touch debounce starts above raised threshold; field 1 validates after two ticks.
// - Release debounce 0 releases on the first tick below lowered threshold.
// - Debounce counts consecutive qualifying samples, one sample per scan period.
// - Report-all mode reports every touch and proximity.
// - Report-single reports one touch plus proximity, ignoring others until release.
// - Report-strongest reports the strongest sensor, switching when another leads it by the switch margin.
// - Single and strongest modes imply proximity on the level output, not in touch_status, while a button is reported.
// - Interrupt output asserts on touch, on release, or on both.
// - Averaging stops for a sensor once its average reaches the freeze threshold.
// - Three or more frozen sensors at once start offset compensation.
// - Negative counter counts low ticks; reaching its limit starts compensation.
// - Compensation acquires fresh offset values so idle ticks return near zero.
// - Stuck timer expiry compensates and releases; next real touch reports normally.
// - A stuck timeout of zero disables the stuck timer.
// - Switch margin only acts in strongest mode.
// - Strongest report changes only on its release or when a rival beats it by the margin.
// - Mode codes: 00 all, 01 single, 10 strongest, 11 reserved.
// - Interrupt codes: 00 masked, 01 touch, 10 release, 11 both.
// - Touch debounce codes: 00 none, 01 two, 10 three, 11 four samples.
// - Stuck timeout counts whole seconds from 1 to 255; 0 is off.
`ifndef TDR_CFG_SVH
`define TDR_CFG_SVH
`define TDR_NSENS 8
`define TDR_TICK_W 16
`define TDR_THR_W 10
`define TDR_PROX 0
`define TDR_MODE_ALL 2'h0
`define TDR_MODE_SINGLE 2'h1
`define TDR_MODE_STRONG 2'h2
`define TDR_IRQ_TOUCH 2'h1
`define TDR_IRQ_RELEASE 2'h2
`define TDR_IRQ_BOTH 2'h3
`define TDR_DEB_MAX 3'h3
`define TDR_PCT_FULL 32'sh64
`define TDR_STEP 32'sh4
`define TDR_FREEZE_MIN 4'h3
`define TDR_SEC_NS 1000000000
`define TDR_CLK_NS 50
`define TDR_PRE_W 25
`endif

// ==== common/tdr_pkg.sv ====
// Types shared by the touch decision and reporting block.
`include "tdr_cfg.svh"
package tdr_pkg;
  typedef logic signed [`TDR_TICK_W-1:0] tdr_tick_t;
  typedef tdr_tick_t [`TDR_NSENS-1:0] tdr_ticks_t;
  typedef logic [`TDR_THR_W-1:0] tdr_thr_t;
  typedef tdr_thr_t [`TDR_NSENS-1:0] tdr_thrs_t;
  typedef logic signed [31:0] tdr_wide_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] irq_sel;
    logic rel_deb;
    logic [2:0] touch_deb;
  } tdr_btn_cfg_t;
  typedef struct packed {
    logic [7:0] hyst_pct;
    logic [7:0] avg_thr;
    logic [7:0] neg_thr;
    logic [7:0] neg_lim;
    logic [7:0] stuck_s;
    logic [7:0] margin;
  } tdr_tune_t;
  typedef struct packed {
    logic hit;
    logic [2:0] idx;
  } tdr_pick_t;
  typedef enum logic [1:0] {ST_IDLE, ST_TOUCH, ST_STUCK} tdr_state_t;
  typedef enum logic {CP_IDLE, CP_WAIT} tdr_comp_t;
endpackage

// ==== hw/tdr_sensor.sv ====
// Touch, release, stuck and negative-tick decisions for one sensor.
`timescale 1ns/10ps
`default_nettype none
`include "tdr_cfg.svh"
module tdr_sensor (
  input wire logic mclk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic sample, // Scan sample strobe.
  input wire logic sec_pulse, // One-second strobe.
  input wire logic comp_clear, // Offsets were refreshed.
  input wire tdr_pkg::tdr_tick_t ticks, // Tick value.
  input wire tdr_pkg::tdr_tick_t avg, // Filter average.
  input wire tdr_pkg::tdr_thr_t thr, // Sensor threshold.
  input wire tdr_pkg::tdr_btn_cfg_t cfg, // Button configuration.
  input wire tdr_pkg::tdr_tune_t tune, // Shared tuning.
  output logic det, // Touch decision.
  output logic freeze, // Averaging frozen.
  output logic neg_trip, // Negative limit reached.
  output logic stuck_trip // Stuck timer expired.
);
  import tdr_pkg::*;
  tdr_state_t st_q, st_d;
  logic [2:0] deb_q, deb_d, need_t, need_r;
  logic [7:0] sec_q, sec_d, neg_q, neg_d;
  logic frz_q, frz_d, nt_q, nt_d, sk_q, sk_d;
  tdr_wide_t t100, thr_w;
  logic above, below, negp;

  // Compare at a scale of 100 so that no divider is needed.
  always_comb
  begin
    t100 = tdr_wide_t'(ticks) * `TDR_PCT_FULL;
    thr_w = tdr_wide_t'({1'b0, thr});
    above = t100 > thr_w * (`TDR_PCT_FULL + tdr_wide_t'({1'b0, tune.hyst_pct}));
    below = t100 < thr_w * (`TDR_PCT_FULL - tdr_wide_t'({1'b0, tune.hyst_pct}));
    negp = tdr_wide_t'(ticks) < -(tdr_wide_t'({1'b0, tune.neg_thr}) * `TDR_STEP);
    need_t = (cfg.touch_deb > `TDR_DEB_MAX) ? 3'h4 : cfg.touch_deb + 3'h1;
    need_r = {2'h0, cfg.rel_deb} + 3'h1;
  end

  // Decision state, debounce, stuck timer and negative counter.
  always_comb
  begin
    st_d = st_q;
    deb_d = deb_q;
    sec_d = sec_q;
    neg_d = comp_clear ? 8'h0 : neg_q;
    frz_d = frz_q;
    nt_d = 1'b0;
    sk_d = 1'b0;
    if (sample)
    begin
      frz_d = tdr_wide_t'(avg) >= tdr_wide_t'({1'b0, tune.avg_thr}) * `TDR_STEP;
      neg_d = negp ? neg_q + {7'h0, (neg_q != 8'hFF)} : 8'h0;
      if (negp && tune.neg_lim != 8'h0 && neg_q + 8'h1 >= tune.neg_lim)
      begin
        nt_d = 1'b1;
        neg_d = 8'h0;
      end
    end
    case (st_q)
      ST_IDLE:
      begin
        if (sample)
          deb_d = above ? deb_q + 3'h1 : 3'h0;
        if (sample && above && deb_q + 3'h1 >= need_t)
        begin
          st_d = ST_TOUCH;
          deb_d = 3'h0;
        end
      end
      ST_TOUCH:
      begin
        if (sample)
          deb_d = below ? deb_q + 3'h1 : 3'h0;
        if (sample && below && deb_q + 3'h1 >= need_r)
        begin
          st_d = ST_IDLE;
          deb_d = 3'h0;
        end
        else if (sec_pulse && tune.stuck_s != 8'h0)
        begin
          sec_d = sec_q + 8'h1;
          if (sec_q + 8'h1 >= tune.stuck_s)
          begin
            st_d = ST_STUCK;
            sk_d = 1'b1;
          end
        end
      end
      ST_STUCK:
      begin
        if (sample && below)
          st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (st_d != ST_TOUCH)
      sec_d = 8'h0;
  end

  // Register stage of the sensor state.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= ST_IDLE;
      deb_q <= 3'h0;
      sec_q <= 8'h0;
      neg_q <= 8'h0;
      frz_q <= 1'b0;
      nt_q <= 1'b0;
      sk_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      deb_q <= deb_d;
      sec_q <= sec_d;
      neg_q <= neg_d;
      frz_q <= frz_d;
      nt_q <= nt_d;
      sk_q <= sk_d;
    end
  end

  assign det = (st_q == ST_TOUCH);
  assign freeze = frz_q;
  assign neg_trip = nt_q;
  assign stuck_trip = sk_q;
endmodule // tdr_sensor
`default_nettype wire

// ==== hw/tdr_core.sv ====
// Touch decision, reporting, interrupt and compensation control.
`timescale 1ns/10ps
`default_nettype none
`include "tdr_cfg.svh"
module tdr_core #(
  parameter int unsigned SEC_CYCLES = `TDR_SEC_NS / `TDR_CLK_NS // Cycles per second.
) (
  input wire logic mclk, // System clock, 20 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic scan_sample, // One pulse per scan period.
  input wire tdr_pkg::tdr_ticks_t ticks, // Tick values.
  input wire tdr_pkg::tdr_ticks_t averages, // Filter averages.
  input wire tdr_pkg::tdr_thrs_t sensor_threshold, // Thresholds.
  input wire tdr_pkg::tdr_btn_cfg_t button_config, // Configuration.
  input wire tdr_pkg::tdr_tune_t tune, // Shared tuning.
  input wire logic irq_ack, // Clears the interrupt.
  input wire logic offsets_ack, // New offsets taken.
  output logic [`TDR_NSENS-1:0] touch_status, // Reported state.
  output logic report_valid, // A button is reported.
  output logic [2:0] report_index, // Reported button.
  output logic aoi_prox, // Proximity for level output.
  output logic [`TDR_NSENS-1:0] avg_freeze, // Averaging frozen.
  output logic offset_refresh_req, // Compensation running.
  output logic irq_out_n // Interrupt, active low.
);
  import tdr_pkg::*;

  logic [`TDR_NSENS-1:0] det, ntrip, strip;
  logic [`TDR_PRE_W-1:0] pre_q, pre_d;
  logic sec_q, sec_d;
  logic scan_q;
  logic rv_q, rv_d;
  logic [2:0] ri_q, ri_d;
  logic [`TDR_NSENS-1:0] ts_q, ts_d;
  logic ap_q, ap_d;
  logic irqn_q, irqn_d;
  logic multi_q, multi_d;
  logic clr_q, clr_d;
  tdr_comp_t cp_q, cp_d;
  tdr_pick_t best, low;
  logic cur_held, gap_ok, one_rep;
  logic touch_ev, rel_ev, irq_set, trig;

  // True for the modes that report a single button.
  function automatic logic single_report(input logic [1:0] mode);
    single_report = (mode == `TDR_MODE_SINGLE) || (mode == `TDR_MODE_STRONG);
  endfunction

  // Lowest touched button; proximity is not a button.
  function automatic tdr_pick_t lowest_button(input logic [`TDR_NSENS-1:0] d);
    tdr_pick_t p;
    p = '0;
    for (int i = `TDR_NSENS - 1; i > `TDR_PROX; i--)
    begin
      if (d[i])
      begin
        p.hit = 1'b1;
        p.idx = 3'(i);
      end
    end
    lowest_button = p;
  endfunction

  // Touched button with the largest tick value; ties keep the lowest.
  function automatic tdr_pick_t strongest_button(
    input logic [`TDR_NSENS-1:0] d,
    input tdr_ticks_t t
  );
    tdr_pick_t p;
    p = '0;
    for (int i = `TDR_PROX + 1; i < `TDR_NSENS; i++)
    begin
      if (d[i] && (!p.hit || $signed(t[i]) > $signed(t[p.idx])))
      begin
        p.hit = 1'b1;
        p.idx = 3'(i);
      end
    end
    strongest_button = p;
  endfunction

  // Number of sensors whose averaging is frozen.
  function automatic logic [3:0] count_set(input logic [`TDR_NSENS-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < `TDR_NSENS; i++)
      n = n + {3'h0, v[i]};
    count_set = n;
  endfunction

  // One decision engine per sensor; sensor 0 is the proximity sensor.
  generate
    for (genvar g = 0; g < `TDR_NSENS; g++)
    begin : g_sens
      tdr_sensor u_sens (
        .mclk(mclk),
        .reset_n(reset_n),
        .sample(scan_sample),
        .sec_pulse(sec_q),
        .comp_clear(clr_q),
        .ticks(ticks[g]),
        .avg(averages[g]),
        .thr(sensor_threshold[g]),
        .cfg(button_config),
        .tune(tune),
        .det(det[g]),
        .freeze(avg_freeze[g]),
        .neg_trip(ntrip[g]),
        .stuck_trip(strip[g])
      );
    end
  endgenerate

  // Free-running one-second prescaler. It is not phase-locked to the
  // touch, so the first stuck second may be up to one second short.
  always_comb
  begin
    pre_d = pre_q + `TDR_PRE_W'(1);
    sec_d = 1'b0;
    if (pre_q >= `TDR_PRE_W'(SEC_CYCLES - 1))
    begin
      pre_d = '0;
      sec_d = 1'b1;
    end
  end

  // Report selection runs one cycle after the scan strobe so that the
  // sensor decisions of that scan are already settled.
  always_comb
  begin
    rv_d = rv_q;
    ri_d = ri_q;
    ts_d = ts_q;
    ap_d = ap_q;
    best = strongest_button(det, ticks);
    low = lowest_button(det);
    one_rep = single_report(button_config.mode);
    cur_held = rv_q && det[ri_q];
    gap_ok = tdr_wide_t'(ticks[best.idx]) >=
      tdr_wide_t'(ticks[ri_q]) + tdr_wide_t'({1'b0, tune.margin});
    if (scan_q)
    begin
      case (button_config.mode)
        `TDR_MODE_SINGLE:
        begin
          if (!cur_held)
          begin
            rv_d = low.hit;
            ri_d = low.idx;
          end
        end
        `TDR_MODE_STRONG:
        begin
          if (!cur_held)
          begin
            rv_d = best.hit;
            ri_d = best.idx;
          end
          else if (best.idx != ri_q && gap_ok)
            ri_d = best.idx;
        end
        default:
        begin
          rv_d = 1'b0;
          ri_d = 3'h0;
        end
      endcase
      if (one_rep)
      begin
        ts_d = '0;
        ts_d[ri_d] = rv_d;
        ts_d[`TDR_PROX] = det[`TDR_PROX];
      end
      else
        ts_d = det;
      ap_d = det[`TDR_PROX] || (one_rep && rv_d);
    end
  end

  // Interrupt events come from changes of the reported state. A new
  // event in the cycle of the acknowledge keeps the line asserted.
  always_comb
  begin
    touch_ev = |(ts_d & ~ts_q);
    rel_ev = |(ts_q & ~ts_d);
    case (button_config.irq_sel)
      `TDR_IRQ_TOUCH: irq_set = touch_ev;
      `TDR_IRQ_RELEASE: irq_set = rel_ev;
      `TDR_IRQ_BOTH: irq_set = touch_ev || rel_ev;
      default: irq_set = 1'b0;
    endcase
    irqn_d = !(irq_set || (!irqn_q && !irq_ack));
  end

  // Compensation control. Requests that arrive while one is running are
  // absorbed by it, as the refresh covers every sensor. A trigger in the
  // cycle of the acknowledge starts a fresh round, as its ticks predate it.
  always_comb
  begin
    multi_d = count_set(avg_freeze) >= `TDR_FREEZE_MIN;
    trig = (multi_d && !multi_q) || (|ntrip) || (|strip);
    cp_d = cp_q;
    clr_d = 1'b0;
    case (cp_q)
      CP_IDLE:
      begin
        if (trig)
          cp_d = CP_WAIT;
      end
      CP_WAIT:
      begin
        if (offsets_ack)
        begin
          cp_d = trig ? CP_WAIT : CP_IDLE;
          clr_d = 1'b1;
        end
      end
      default: cp_d = CP_IDLE;
    endcase
  end

  // Register stage of the reporting, interrupt and compensation state.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_q <= '0;
      sec_q <= 1'b0;
      scan_q <= 1'b0;
      rv_q <= 1'b0;
      ri_q <= 3'h0;
      ts_q <= '0;
      ap_q <= 1'b0;
      irqn_q <= 1'b1;
      multi_q <= 1'b0;
      clr_q <= 1'b0;
      cp_q <= CP_IDLE;
    end
    else
    begin
      pre_q <= pre_d;
      sec_q <= sec_d;
      scan_q <= scan_sample;
      rv_q <= rv_d;
      ri_q <= ri_d;
      ts_q <= ts_d;
      ap_q <= ap_d;
      irqn_q <= irqn_d;
      multi_q <= multi_d;
      clr_q <= clr_d;
      cp_q <= cp_d;
    end
  end

  assign touch_status = ts_q;
  assign report_valid = rv_q;
  assign report_index = ri_q;
  assign aoi_prox = ap_q;
  assign offset_refresh_req = (cp_q == CP_WAIT);
  assign irq_out_n = irqn_q;

  // A reported touch with touch interrupts enabled pulls the line low.
  AST_IRQ_TOUCH: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (|(ts_d & ~ts_q) && button_config.irq_sel == `TDR_IRQ_TOUCH)
      |=> !irq_out_n)
    else $error("touch event did not assert the interrupt");

  // A release with release interrupts enabled pulls the line low.
  AST_IRQ_RELEASE: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (|(ts_q & ~ts_d) && button_config.irq_sel == `TDR_IRQ_RELEASE)
      |=> !irq_out_n)
    else $error("release event did not assert the interrupt");

  // Masked interrupts never pull an idle line low.
  AST_IRQ_MASKED: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (irq_out_n && button_config.irq_sel == 2'h0) |=> irq_out_n)
    else $error("masked interrupt asserted");

  // In report-all mode the status mirrors every sensor decision.
  AST_ALL_MIRROR: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (scan_q && button_config.mode == `TDR_MODE_ALL)
      |=> (touch_status == $past(det) && !report_valid))
    else $error("report-all status differs from decisions");

  // In single mode a held report is not taken over by another button.
  AST_SINGLE_HOLD: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (scan_q && button_config.mode == `TDR_MODE_SINGLE && report_valid
      && det[report_index])
      |=> (report_valid && report_index == $past(report_index)))
    else $error("single report moved while first touch held");

  // In strongest mode a switch needs the rival to lead by the margin.
  AST_STRONG_MARGIN: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (scan_q && button_config.mode == `TDR_MODE_STRONG && cur_held
      && ri_d != ri_q)
      |-> (tdr_wide_t'(ticks[ri_d]) >=
        tdr_wide_t'(ticks[ri_q]) + tdr_wide_t'({1'b0, tune.margin})))
    else $error("strongest report switched inside the margin");

  // A reported button always implies proximity on the level output.
  AST_PROX_IMPLIED: assert property (
    @(posedge mclk) disable iff (!reset_n)
    report_valid |-> aoi_prox)
    else $error("button reported without implied proximity");

  // Three frozen sensors start compensation within two cycles.
  AST_COMP_FREEZE: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (count_set(avg_freeze) >= `TDR_FREEZE_MIN && !multi_q)
      |-> ##[1:2] offset_refresh_req)
    else $error("frozen sensors did not start compensation");

  // A negative-counter trip starts compensation on the next cycle.
  AST_COMP_NEG: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (|ntrip) |=> offset_refresh_req)
    else $error("negative ticks did not start compensation");

  // A stuck expiry releases the sensor and starts compensation.
  AST_STUCK_REL: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (|strip) |-> ((strip & det) == '0 ##1 offset_refresh_req))
    else $error("stuck expiry did not release and compensate");

  // With the stuck timeout at zero no stuck expiry happens.
  AST_STUCK_OFF: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (tune.stuck_s == 8'h0 && $stable(tune.stuck_s)) |=> (strip == '0))
    else $error("stuck timer fired while disabled");

  // The second strobe coincides with the prescaler wrap and lasts one cycle.
  AST_SEC_PERIOD: assert property (
    @(posedge mclk) disable iff (!reset_n)
    sec_q |-> (pre_q == '0) ##1 !sec_q)
    else $error("second strobe out of step with the prescaler");
endmodule // tdr_core
`default_nettype wire

// ==== testbench/tdr_host_model.sv ====
// Host side model that acknowledges interrupts and offset refresh requests.
`timescale 1ns/10ps
`default_nettype none
module tdr_host_model #(
  parameter int ACK_DLY = 4 // Cycles the host waits before it answers.
) (
  input wire logic mclk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic irq_out_n, // Interrupt from the block, active low.
  input wire logic offset_refresh_req, // Compensation request from the block.
  output logic irq_ack, // One-cycle interrupt acknowledge.
  output logic offsets_ack // One-cycle acknowledge of fresh offsets.
);
  int irq_wait;
  int comp_wait;

  // The host answers late on purpose, so the bench can see the low level first.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_wait <= 0;
      comp_wait <= 0;
      irq_ack <= 1'b0;
      offsets_ack <= 1'b0;
    end
    else
    begin
      irq_wait <= (!irq_out_n && !irq_ack) ? irq_wait + 1 : 0;
      irq_ack <= (irq_wait == ACK_DLY);
      comp_wait <= (offset_refresh_req && !offsets_ack) ? comp_wait + 1 : 0;
      offsets_ack <= (comp_wait == ACK_DLY);
    end
  end
endmodule // tdr_host_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the touch decision and reporting core.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tdr_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic scan_sample = 1'b0;
  tdr_ticks_t ticks = '0;
  tdr_ticks_t averages = '0;
  tdr_thrs_t sensor_threshold = {8{10'h064}};
  tdr_btn_cfg_t button_config = tdr_btn_cfg_t'(8'h70);
  tdr_tune_t tune = {8'h0A, 8'h50, 8'hA0, 8'h01, 8'h00, 8'h80};
  logic irq_ack;
  logic offsets_ack;
  logic [7:0] touch_status;
  logic report_valid;
  logic [2:0] report_index;
  logic aoi_prox;
  logic [7:0] avg_freeze;
  logic offset_refresh_req;
  logic irq_out_n;
  tdr_ticks_t tk = '0;
  tdr_ticks_t av = '0;
  logic irq_seen = 1'b0;
  logic req_seen = 1'b0;
  int bad_count = 0;
  int num_checks = 0;

  // A short second keeps the stuck timer within a few scans.
  tdr_core #(.SEC_CYCLES(20)) i_tdr_core (
    .mclk(mclk), .reset_n(reset_n), .scan_sample(scan_sample), .ticks(ticks),
    .averages(averages), .sensor_threshold(sensor_threshold),
    .button_config(button_config), .tune(tune), .irq_ack(irq_ack),
    .offsets_ack(offsets_ack), .touch_status(touch_status), .report_valid(report_valid),
    .report_index(report_index), .aoi_prox(aoi_prox), .avg_freeze(avg_freeze),
    .offset_refresh_req(offset_refresh_req), .irq_out_n(irq_out_n));

  tdr_host_model i_tdr_host_model (
    .mclk(mclk), .reset_n(reset_n), .irq_out_n(irq_out_n),
    .offset_refresh_req(offset_refresh_req), .irq_ack(irq_ack), .offsets_ack(offsets_ack));

  // Clock at 20 MHz.
  always #25 mclk = ~mclk;

  // Sticky flags catch short levels that the host clears before a task looks.
  always @(posedge mclk)
  begin
    if (!irq_out_n)
      irq_seen = 1'b1;
    if (offset_refresh_req)
      req_seen = 1'b1;
  end

  task automatic finish_test();
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Each scan leaves two cycles so the status outputs have settled on return.
  task automatic scan(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      ticks <= tk;
      averages <= av;
      scan_sample <= 1'b1;
      @(posedge mclk);
      scan_sample <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    #1;
  endtask

  task automatic cfgset(input logic [7:0] c);
    @(posedge mclk);
    button_config <= tdr_btn_cfg_t'(c);
  endtask

  task automatic idle();
    tk = '0;
    av = '0;
    scan(2);
    repeat (12) @(posedge mclk);
    irq_seen = 1'b0;
    req_seen = 1'b0;
  endtask

  task automatic t_hyst();
    cfgset(8'h70);
    tk[1] = 16'sh006E;
    scan(1);
    chk(touch_status, 8'h00);
    tk[1] = 16'sh006F;
    scan(1);
    chk(touch_status, 8'h02);
    tk[1] = 16'sh005A;
    scan(1);
    chk(touch_status, 8'h02);
    tk[1] = 16'sh0059;
    scan(1);
    chk(touch_status, 8'h00);
    idle();
  endtask

  task automatic t_deb();
    for (int d = 0; d < 4; d++)
    begin
      cfgset({5'b01110, d[2:0]});
      tk[3] = 16'sh00C8;
      scan(d);
      chk(touch_status, 8'h00);
      scan(1);
      chk(touch_status, 8'h08);
      idle();
    end
    cfgset(8'h78);
    tk[3] = 16'sh00C8;
    scan(1);
    tk[3] = 16'sh0000;
    scan(1);
    chk(touch_status, 8'h08);
    scan(1);
    chk(touch_status, 8'h00);
    idle();
  endtask

  task automatic t_modes();
    logic [7:0] exp [4] = '{8'h06, 8'h02, 8'h02, 8'h06};
    for (int m = 0; m < 4; m++)
    begin
      cfgset({m[1:0], 6'b110000});
      tk[1] = 16'sh00C8;
      scan(1);
      tk[2] = 16'sh00C8;
      scan(1);
      chk(touch_status, exp[m]);
      if (m == 1)
      begin
        chk({7'h00, report_valid}, 8'h01);
        chk({5'h00, report_index}, 8'h01);
        chk({7'h00, aoi_prox}, 8'h01);
      end
      idle();
    end
    // Proximity alone in single mode reports no button but sets the level.
    cfgset(8'h70);
    tk[0] = 16'sh00C8;
    scan(1);
    chk(touch_status, 8'h01);
    chk({7'h00, report_valid}, 8'h00);
    chk({7'h00, aoi_prox}, 8'h01);
    idle();
  endtask

  task automatic t_strong();
    cfgset(8'hB0);
    tune.margin <= 8'h14;
    tk[1] = 16'sh00C8;
    scan(1);
    tk[2] = 16'sh00DB;
    scan(1);
    chk({5'h00, report_index}, 8'h01);
    tk[2] = 16'sh00DC;
    scan(1);
    chk({5'h00, report_index}, 8'h02);
    chk({7'h00, aoi_prox}, 8'h01);
    idle();
    tune.margin <= 8'h80;
  endtask

  task automatic t_irq();
    for (int s = 0; s < 4; s++)
    begin
      cfgset({2'b01, s[1:0], 4'h0});
      irq_seen = 1'b0;
      tk[4] = 16'sh00C8;
      scan(1);
      repeat (12) @(posedge mclk);
      chk({7'h00, irq_seen}, {7'h00, s[0]});
      chk({7'h00, irq_out_n}, 8'h01);
      irq_seen = 1'b0;
      tk[4] = 16'sh0000;
      scan(1);
      repeat (12) @(posedge mclk);
      chk({7'h00, irq_seen}, {7'h00, s[1]});
    end
    idle();
  endtask

  task automatic t_comp();
    cfgset(8'h70);
    tk[2] = -16'sd640;
    scan(2);
    chk({7'h00, req_seen}, 8'h00);
    tk[2] = -16'sd641;
    scan(1);
    chk({7'h00, offset_refresh_req}, 8'h01);
    repeat (12) @(posedge mclk);
    chk({7'h00, offset_refresh_req}, 8'h00);
    idle();
    av[1] = 16'sh0140;
    av[2] = 16'sh0140;
    av[4] = 16'sh013F;
    scan(1);
    chk(avg_freeze, 8'h06);
    chk({7'h00, req_seen}, 8'h00);
    av[3] = 16'sh0140;
    scan(1);
    chk(avg_freeze, 8'h0E);
    chk({7'h00, req_seen}, 8'h01);
    idle();
  endtask

  task automatic t_stuck();
    cfgset(8'h70);
    tune.stuck_s <= 8'h01;
    tk[5] = 16'sh00C8;
    scan(1);
    chk(touch_status, 8'h20);
    scan(15);
    chk(touch_status, 8'h00);
    chk({7'h00, req_seen}, 8'h01);
    tk[5] = 16'sh0000;
    scan(1);
    tk[5] = 16'sh00C8;
    scan(1);
    chk(touch_status, 8'h20);
    idle();
    tune.stuck_s <= 8'h00;
    tk[5] = 16'sh00C8;
    scan(16);
    chk(touch_status, 8'h20);
    idle();
  endtask

  // Main sequence after a reset of twelve cycles.
  initial
  begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk({7'h00, irq_out_n}, 8'h01);
    t_hyst();
    t_deb();
    t_modes();
    t_strong();
    t_irq();
    t_comp();
    t_stuck();
    finish_test();
  end

  // Watchdog well past the fewer than a thousand cycles the tests need.
  initial
  begin
    #(20000 * 50);
    bad_count++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
